//--- verilog/ddrc_pkg.sv
// Constants, memory command codes and the operation carrier of the controller.
// Assumes the core and link sides both import this package.
package ddrc_pkg;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int BANK_W = 2;
	localparam int DATA_W = 16;
	localparam int MASK_W = DATA_W / 8;
	localparam int ADDR_W = ROW_W + BANK_W + COL_W;
	localparam int TAP_W = 3;
	localparam int CAS_LAT_DEF = 3;
	localparam int BURST_LEN_DEF = 4;
	localparam int REF_BURST_DEF = 2;
	localparam int DQ_PER_STROBE_DEF = 8;
	localparam logic [1:0] INIT_LAST = 2'h3;
	localparam logic [ROW_W-1:0] MODE_REG_DEF = 13'h0032;
	localparam logic [5:0] REP_MAX_DDR2 = 6'h20;
	localparam logic [3:0] UC_READ = 4'h1;
	localparam logic [3:0] UC_WRITE = 4'h2;
	localparam logic [3:0] UC_READA = 4'h3;
	localparam logic [3:0] UC_WRITEA = 4'h4;
	localparam logic [3:0] UC_PDOWN = 4'h5;
	localparam logic [3:0] UC_LOAD_MR = 4'h6;
	localparam logic [3:0] UC_SELF_REF = 4'h7;
	localparam logic [2:0] MC_NOP = 3'h7;
	localparam logic [2:0] MC_ACT = 3'h3;
	localparam logic [2:0] MC_RD = 3'h5;
	localparam logic [2:0] MC_WR = 3'h4;
	localparam logic [2:0] MC_PRE = 3'h2;
	localparam logic [2:0] MC_REF = 3'h1;
	localparam logic [2:0] MC_MRS = 3'h0;
	typedef enum logic [2:0] {
		OP_NOP, OP_PRE, OP_REF, OP_MRS, OP_RD, OP_WR
	} ddrc_op_e;
	typedef struct packed {
		ddrc_op_e kind;
		logic auto_pre;
		logic cke;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [DATA_W-1:0] wdata;
		logic [MASK_W-1:0] mask;
	} ddrc_mem_op_s;
endpackage

//--- verilog/ddrc_top.sv
// DDR/DDR2 SDRAM controller: user side on ref_clk_i, memory pins on link_clk_i.
// Assumes user logic is synchronous to ref_clk_i and pins are on link_clk_i.
// Overview of operation
// R1 - Active-low asynchronous reset returns all state to reset values.
// R2 - User waits 200 us after power-on before requesting initialization.
// R3 - Initialization complete is pulsed high for exactly one clock.
// R4 - Command valid qualifies command, address and repeat count together.
// R5 - Command ready is high only when the next command can be taken.
// R6 - Five-bit repeat count repeats reads or writes when the option is on.
// R7 - Write data ready is high when write data is being taken.
// R8 - Each write mask bit suppresses its matching write data byte.
// R9 - Read data valid is high exactly when read data is valid.
// R10 - Refresh request and acknowledge act only with external refresh on.
// R11 - DDR1 mode drives a system clock output for user logic.
// R12 - DDR2 mode receives system clock and a 270 or 90 degree copy; the code leaves system_clock_270_i and system_clock_90_i unused.
// R13 - Burst termination input acts only in DDR1 mode, active high.
// R14 - Read gate tap delays read capture to cover board routing.
// R15 - DDR2 mode drives strobe loop update and takes its delay code.
// R16 - Row and column share address pins; bank has its own pins.
// R17 - Memory byte masks are active high, one per eight data bits.
// R18 - Each data strobe serves a group of 4 or 8 data pins.
// R19 - Row, column, write and chip selects low; clock enable high.
// R20 - Termination outputs, one per chip select, active only in DDR2.
// R21 - A command is taken only when ready and valid are both high.
// R22 - User holds initialization request until the completion pulse.
// R23 - After the refresh burst, acknowledge pulses high for one clock.
// R24 - User side signals are sampled and driven on the system clock.
`timescale 1ns/1ps
module ddrc_top #(
	parameter bit DDR2_MODE = 1'b0,
	parameter bit REPEAT_EN = 1'b1,
	parameter bit EXT_REF_EN = 1'b1,
	parameter int CAS_LAT = ddrc_pkg::CAS_LAT_DEF,
	parameter int BURST_LEN = ddrc_pkg::BURST_LEN_DEF,
	parameter int REF_BURST = ddrc_pkg::REF_BURST_DEF,
	parameter int DQ_PER_STROBE = ddrc_pkg::DQ_PER_STROBE_DEF,
	parameter int CS_WIDTH = 1,
	parameter int CKE_WIDTH = 1,
	parameter int CLKO_WIDTH = 1
) (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic link_clk_i,
	input wire logic system_clock_270_i,
	input wire logic system_clock_90_i,
	output logic sys_clk_o,
	input wire logic init_start_i,
	output logic init_done_o,
	input wire logic ext_refresh_i,
	output logic ext_refresh_ack_o,
	input wire logic [3:0] cmd_i,
	input wire logic cmd_valid_i,
	input wire logic [ddrc_pkg::ADDR_W-1:0] addr_i,
	input wire logic [4:0] repeat_count_i,
	input wire logic burst_term_i,
	output logic cmd_rdy_o,
	output logic wr_data_rdy_o,
	input wire logic [ddrc_pkg::DATA_W-1:0] write_data_i,
	input wire logic [ddrc_pkg::MASK_W-1:0] write_mask_i,
	output logic [ddrc_pkg::DATA_W-1:0] read_data_o,
	output logic read_data_valid_o,
	input wire logic [ddrc_pkg::TAP_W-1:0] read_gate_tap_i,
	output logic dll_update_n_o,
	input wire logic strobe_delay_i,
	output logic [CLKO_WIDTH-1:0] memory_clock_out_o,
	output logic [CKE_WIDTH-1:0] memory_clock_enable_o,
	output logic [ddrc_pkg::ROW_W-1:0] memory_row_col_address_o,
	output logic [ddrc_pkg::BANK_W-1:0] memory_bank_select_o,
	input wire logic [ddrc_pkg::DATA_W-1:0] memory_data_pins_i,
	output logic [ddrc_pkg::DATA_W-1:0] memory_data_pins_o,
	output logic [ddrc_pkg::DATA_W-1:0] memory_data_pins_oe_o,
	output logic [ddrc_pkg::MASK_W-1:0] memory_byte_mask_o,
	input wire logic [ddrc_pkg::DATA_W/DQ_PER_STROBE-1:0]
		memory_data_strobe_i,
	output logic [ddrc_pkg::DATA_W/DQ_PER_STROBE-1:0] memory_data_strobe_o,
	output logic [ddrc_pkg::DATA_W/DQ_PER_STROBE-1:0]
		memory_data_strobe_oe_o,
	output logic [CS_WIDTH-1:0] memory_chip_select_low_o,
	output logic memory_row_strobe_low_o,
	output logic memory_column_strobe_low_o,
	output logic memory_write_enable_low_o,
	output logic [CS_WIDTH-1:0] memory_termination_control_o
);
	import ddrc_pkg::*;

	localparam int DQS_W = DATA_W / DQ_PER_STROBE;
	// Read latency adds the command register, two pin synchroniser stages
	// and the optional later capture stage to the CAS latency.
	localparam logic [TAP_W+3:0] LAT_BASE = (TAP_W+4)'(CAS_LAT + 4);

	typedef enum logic [2:0] {
		C_WAIT_INIT, C_INIT, C_IDLE, C_WDATA, C_ISSUE, C_BUSY
	} ddrc_core_e;
	typedef enum logic [2:0] {L_IDLE, L_COL, L_LAT, L_DONE} ddrc_link_e;

	ddrc_core_e core_st_ff, nxt_st;
	ddrc_mem_op_s op_ff, nxt_op, uop, init_op;
	logic [1:0] init_idx_ff, nxt_idx;
	logic [5:0] rep_left_ff, nxt_rep, rep_val;
	logic [7:0] ref_left_ff, nxt_refl;
	logic ext_ref_ff, nxt_ext, inited_ff, nxt_inited;
	logic req_tgl_ff, nxt_req, ref_hold_ff;
	logic init_done_ff, nxt_done, ref_ack_ff, nxt_ack;
	logic rd_valid_ff, nxt_rdv;
	logic [DATA_W-1:0] rd_data_ff, nxt_rdd;
	logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
	logic [TAP_W-1:0] tap_ff;
	logic ack_evt, is_rd, is_wr, cmd_legal, cmd_take, ref_go, rw_more;

	// Link domain state.
	ddrc_link_e lst_ff;
	ddrc_mem_op_s lop_ff;
	logic rq_s1_ff, rq_s2_ff, rq_s3_ff, ack_tgl_ff, start;
	logic dly_s1_ff, dly_s2_ff;
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff, link_rdata_ff;
	logic [TAP_W+3:0] lat_ff;
	logic [2:0] mcmd_ff;
	logic cs_n_ff, cke_ff, odt_ff, dq_oe_ff, upd_n_ff;
	logic [ROW_W-1:0] ma_ff;
	logic [BANK_W-1:0] ba_ff;
	logic [DATA_W-1:0] dq_o_ff;
	logic [MASK_W-1:0] dm_ff;

	// User command decode; address is {row, bank, column}.
	assign is_rd = (cmd_i == UC_READ) || (cmd_i == UC_READA);
	assign is_wr = (cmd_i == UC_WRITE) || (cmd_i == UC_WRITEA);
	assign cmd_legal = (cmd_i >= UC_READ) && (cmd_i <= UC_SELF_REF);
	assign ref_go = EXT_REF_EN && ext_refresh_i && !ref_hold_ff; // [R10]
	assign cmd_rdy_o = (core_st_ff == C_IDLE) && !ref_go; // [R5]
	assign cmd_take = cmd_rdy_o && cmd_valid_i && cmd_legal; // [R4] [R21]
	assign wr_data_rdy_o = (core_st_ff == C_WDATA); // [R7]
	assign rep_val = !REPEAT_EN ? 6'h01 :
		(repeat_count_i != 5'h00) ? {1'b0, repeat_count_i} :
		(DDR2_MODE ? REP_MAX_DDR2 : 6'h01); // [R6]
	assign uop.kind = is_rd ? OP_RD : is_wr ? OP_WR :
		(cmd_i == UC_LOAD_MR) ? OP_MRS :
		(cmd_i == UC_SELF_REF) ? OP_REF : OP_NOP;
	assign uop.auto_pre = (cmd_i == UC_READA) || (cmd_i == UC_WRITEA);
	assign uop.cke = !((cmd_i == UC_PDOWN) || (cmd_i == UC_SELF_REF));
	assign uop.row = addr_i[ADDR_W-1 -: ROW_W];
	assign uop.bank = addr_i[COL_W +: BANK_W];
	assign uop.col = addr_i[COL_W-1:0];
	assign uop.wdata = '0;
	assign uop.mask = '0;
	assign init_op.kind = (init_idx_ff == 2'h0) ? OP_PRE :
		(init_idx_ff == INIT_LAST) ? OP_MRS : OP_REF;
	assign init_op.auto_pre = 1'b1;
	assign init_op.cke = 1'b1;
	assign init_op.bank = '0;
	assign init_op.row = MODE_REG_DEF;
	assign init_op.col = '0;
	assign init_op.wdata = '0;
	assign init_op.mask = '0;
	assign ack_evt = ack_s2_ff ^ ack_s3_ff;
	assign rw_more = (op_ff.kind == OP_RD || op_ff.kind == OP_WR) &&
		(rep_left_ff > 6'h01) && !(burst_term_i && !DDR2_MODE); // [R13]

	always_comb begin
		nxt_st = core_st_ff;
		nxt_op = op_ff;
		nxt_idx = init_idx_ff;
		nxt_rep = rep_left_ff;
		nxt_refl = ref_left_ff;
		nxt_ext = ext_ref_ff;
		nxt_inited = inited_ff;
		nxt_req = req_tgl_ff;
		nxt_done = 1'b0;
		nxt_ack = 1'b0;
		nxt_rdv = 1'b0;
		nxt_rdd = rd_data_ff;
		unique case (core_st_ff)
		C_WAIT_INIT: begin
			if (init_start_i) begin
				nxt_st = C_INIT;
			end
		end
		C_INIT: begin
			nxt_op = init_op;
			nxt_st = C_ISSUE;
		end
		C_IDLE: begin
			if (ref_go) begin
				nxt_op = init_op;
				nxt_op.kind = OP_REF;
				nxt_refl = 8'(REF_BURST);
				nxt_ext = 1'b1;
				nxt_st = C_ISSUE;
			end else if (cmd_take) begin
				nxt_op = uop;
				nxt_rep = rep_val;
				nxt_refl = 8'h01;
				nxt_st = is_wr ? C_WDATA : C_ISSUE;
			end
		end
		C_WDATA: begin
			nxt_op.wdata = write_data_i;
			nxt_op.mask = write_mask_i;
			nxt_st = C_ISSUE;
		end
		C_ISSUE: begin
			nxt_req = ~req_tgl_ff;
			nxt_st = C_BUSY;
		end
		C_BUSY: begin
			if (ack_evt) begin
				if (!inited_ff) begin
					if (init_idx_ff == INIT_LAST) begin
						nxt_done = 1'b1; // [R3]
						nxt_inited = 1'b1;
						nxt_st = C_IDLE;
					end else begin
						nxt_idx = init_idx_ff + 2'h1;
						nxt_st = C_INIT;
					end
				end else if (op_ff.kind == OP_REF &&
					ref_left_ff > 8'h01) begin
					nxt_refl = ref_left_ff - 8'h01;
					nxt_st = C_ISSUE;
				end else if (rw_more) begin
					nxt_rep = rep_left_ff - 6'h01;
					nxt_op.col = op_ff.col + COL_W'(BURST_LEN);
					nxt_st = (op_ff.kind == OP_WR) ? C_WDATA : C_ISSUE;
				end else begin
					nxt_ack = ext_ref_ff; // [R23]
					nxt_ext = 1'b0;
					nxt_st = C_IDLE;
				end
				if (op_ff.kind == OP_RD && inited_ff) begin
					nxt_rdv = 1'b1; // [R9]
					nxt_rdd = link_rdata_ff;
				end
			end
		end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin // [R1]
			core_st_ff <= C_WAIT_INIT;
			op_ff <= '0;
			init_idx_ff <= 2'h0;
			rep_left_ff <= 6'h00;
			ref_left_ff <= 8'h00;
			ext_ref_ff <= 1'b0;
			inited_ff <= 1'b0;
			req_tgl_ff <= 1'b0;
			init_done_ff <= 1'b0;
			ref_ack_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			rd_data_ff <= '0;
			ref_hold_ff <= 1'b0;
			tap_ff <= '0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin // [R24]
			core_st_ff <= nxt_st;
			op_ff <= nxt_op;
			init_idx_ff <= nxt_idx;
			rep_left_ff <= nxt_rep;
			ref_left_ff <= nxt_refl;
			ext_ref_ff <= nxt_ext;
			inited_ff <= nxt_inited;
			req_tgl_ff <= nxt_req;
			init_done_ff <= nxt_done;
			ref_ack_ff <= nxt_ack;
			rd_valid_ff <= nxt_rdv;
			rd_data_ff <= nxt_rdd;
			ref_hold_ff <= nxt_ack || (ref_hold_ff && ext_refresh_i);
			// The tap is held steady while the link works on a request.
			tap_ff <= (core_st_ff == C_ISSUE) ? read_gate_tap_i : tap_ff;
			ack_s1_ff <= ack_tgl_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
		end
	end

	assign init_done_o = init_done_ff;
	assign ext_refresh_ack_o = ref_ack_ff;
	assign read_data_o = rd_data_ff;
	assign read_data_valid_o = rd_valid_ff;
	assign sys_clk_o = ref_clk_i; // [R11] [R12]

	// Link side: executes one operation per request toggle.
	assign start = rq_s2_ff ^ rq_s3_ff;

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rq_s1_ff <= 1'b0;
			rq_s2_ff <= 1'b0;
			rq_s3_ff <= 1'b0;
			dly_s1_ff <= 1'b0;
			dly_s2_ff <= 1'b0;
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
			dq_s3_ff <= '0;
		end else begin
			rq_s1_ff <= req_tgl_ff;
			rq_s2_ff <= rq_s1_ff;
			rq_s3_ff <= rq_s2_ff;
			dly_s1_ff <= strobe_delay_i;
			dly_s2_ff <= dly_s1_ff;
			dq_s1_ff <= memory_data_pins_i;
			dq_s2_ff <= dq_s1_ff;
			dq_s3_ff <= dq_s2_ff;
		end
	end

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lst_ff <= L_IDLE;
			lop_ff <= '0;
			mcmd_ff <= MC_NOP;
			cs_n_ff <= 1'b1;
			cke_ff <= 1'b0;
			ma_ff <= '0;
			ba_ff <= '0;
			dq_o_ff <= '0;
			dq_oe_ff <= 1'b0;
			dm_ff <= '0;
			odt_ff <= 1'b0;
			lat_ff <= '0;
			link_rdata_ff <= '0;
			ack_tgl_ff <= 1'b0;
			upd_n_ff <= 1'b1;
		end else begin
			mcmd_ff <= MC_NOP;
			cs_n_ff <= 1'b1;
			upd_n_ff <= !(DDR2_MODE && lst_ff == L_IDLE); // [R15]
			unique case (lst_ff)
			L_IDLE: begin
				if (start) begin
					lop_ff <= op_ff;
					cke_ff <= op_ff.cke;
					cs_n_ff <= (op_ff.kind == OP_NOP); // [R19]
					ba_ff <= op_ff.bank; // [R16]
					ma_ff <= op_ff.row;
					ma_ff[10] <= op_ff.row[10] |
						(op_ff.auto_pre & op_ff.kind == OP_PRE);
					unique case (op_ff.kind)
					OP_PRE: mcmd_ff <= MC_PRE;
					OP_REF: mcmd_ff <= MC_REF;
					OP_MRS: mcmd_ff <= MC_MRS;
					OP_RD, OP_WR: mcmd_ff <= MC_ACT;
					default: mcmd_ff <= MC_NOP;
					endcase
					lst_ff <= (op_ff.kind == OP_RD ||
						op_ff.kind == OP_WR) ? L_COL : L_DONE;
				end
			end
			L_COL: begin
				cs_n_ff <= 1'b0;
				ma_ff <= ROW_W'(lop_ff.col); // [R16]
				ma_ff[10] <= lop_ff.auto_pre;
				if (lop_ff.kind == OP_WR) begin
					mcmd_ff <= MC_WR;
					dq_o_ff <= lop_ff.wdata;
					dq_oe_ff <= 1'b1;
					dm_ff <= lop_ff.mask; // [R8] [R17]
					odt_ff <= DDR2_MODE; // [R20]
					lst_ff <= L_DONE;
				end else begin
					mcmd_ff <= MC_RD;
					lat_ff <= LAT_BASE + (TAP_W+4)'(tap_ff); // [R14]
					lst_ff <= L_LAT;
				end
			end
			L_LAT: begin
				lat_ff <= lat_ff - 1'b1;
				if (lat_ff == '0) begin
					link_rdata_ff <= (DDR2_MODE && dly_s2_ff) ?
						dq_s3_ff : dq_s2_ff;
					lst_ff <= L_DONE;
				end
			end
			L_DONE: begin
				dq_oe_ff <= 1'b0;
				dm_ff <= '0;
				odt_ff <= 1'b0;
				ack_tgl_ff <= ~ack_tgl_ff;
				lst_ff <= L_IDLE;
			end
			default: lst_ff <= L_IDLE;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < DQS_W; g++) begin : g_strobe
			assign memory_data_strobe_o[g] = dq_oe_ff; // [R18]
			assign memory_data_strobe_oe_o[g] = dq_oe_ff;
		end
	endgenerate

	assign memory_clock_out_o = {CLKO_WIDTH{link_clk_i}};
	assign memory_clock_enable_o = {CKE_WIDTH{cke_ff}};
	assign memory_row_col_address_o = ma_ff;
	assign memory_bank_select_o = ba_ff;
	assign memory_data_pins_o = dq_o_ff;
	assign memory_data_pins_oe_o = {DATA_W{dq_oe_ff}};
	assign memory_byte_mask_o = dm_ff;
	assign memory_chip_select_low_o = {CS_WIDTH{cs_n_ff}};
	assign memory_row_strobe_low_o = mcmd_ff[2];
	assign memory_column_strobe_low_o = mcmd_ff[1];
	assign memory_write_enable_low_o = mcmd_ff[0];
	assign memory_termination_control_o = {CS_WIDTH{odt_ff}};
	assign dll_update_n_o = upd_n_ff;

	property p_init_pulse;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		init_done_o |=> !init_done_o [*2];
	endproperty
	a_init_pulse: assert property (p_init_pulse) // [R3]
		else $error("init done longer than one cycle");

	property p_take;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		cmd_rdy_o && cmd_valid_i && cmd_legal |=> !cmd_rdy_o [*2];
	endproperty
	a_take: assert property (p_take) // [R21]
		else $error("command ready did not drop after a take");

	property p_ignore;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		cmd_rdy_o && !cmd_valid_i && !ext_refresh_i |=> cmd_rdy_o || ref_go;
	endproperty
	a_ignore: assert property (p_ignore) // [R4]
		else $error("idle command slot lost without valid");

	property p_rdy_init;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		cmd_rdy_o |-> inited_ff && $past(core_st_ff) != C_WAIT_INIT;
	endproperty
	a_rdy_init: assert property (p_rdy_init) // [R5]
		else $error("command ready before initialization");

	property p_wr_rdy;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_data_rdy_o |=> !wr_data_rdy_o ##1 !wr_data_rdy_o;
	endproperty
	a_wr_rdy: assert property (p_wr_rdy) // [R7]
		else $error("write data ready stretched");

	property p_rd_valid;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		read_data_valid_o |-> $past(ack_evt) && op_ff.kind == OP_RD;
	endproperty
	a_rd_valid: assert property (p_rd_valid) // [R9]
		else $error("read valid without returned read");

	property p_ref_ack;
		@(posedge ref_clk_i) disable iff (!rstn_i)
		ext_refresh_ack_o |-> EXT_REF_EN && $past(ack_evt) ##1
			!ext_refresh_ack_o;
	endproperty
	a_ref_ack: assert property (p_ref_ack) // [R23]
		else $error("refresh acknowledge malformed");

	property p_odt;
		@(posedge link_clk_i) disable iff (!rstn_i)
		memory_termination_control_o[0] |-> DDR2_MODE &&
			memory_data_pins_oe_o[0];
	endproperty
	a_odt: assert property (p_odt) // [R20]
		else $error("termination outside a DDR2 write");

	property p_mask;
		@(posedge link_clk_i) disable iff (!rstn_i)
		$rose(memory_data_pins_oe_o[0]) |-> memory_byte_mask_o ==
			lop_ff.mask && !memory_write_enable_low_o ##1
			!memory_data_pins_oe_o[0];
	endproperty
	a_mask: assert property (p_mask) // [R17]
		else $error("write beat mask or command wrong");

	property p_idle_cs;
		@(posedge link_clk_i) disable iff (!rstn_i)
		lst_ff == L_IDLE && !start |=> memory_chip_select_low_o[0];
	endproperty
	a_idle_cs: assert property (p_idle_cs) // [R19]
		else $error("chip select active while idle");

	c_init: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		init_done_o);
	c_read: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		read_data_valid_o);
	c_refresh: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		ext_refresh_ack_o);
	c_write: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
		wr_data_rdy_o ##[2:200] wr_data_rdy_o);
endmodule

//--- bench/ddrc_mem_model.sv
// Behavioural SDRAM that answers the controller's memory pins.
// Assumes commands on rising link_clk_i edges and one data beat each.
`timescale 1ns/1ps
module ddrc_mem_model #(
	parameter int CAS_LAT = 3
) (
	input wire logic link_clk_i,
	input wire logic [ddrc_pkg::TAP_W-1:0] tap_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [ddrc_pkg::ROW_W-1:0] addr_i,
	input wire logic [ddrc_pkg::BANK_W-1:0] bank_i,
	input wire logic [ddrc_pkg::DATA_W-1:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic [ddrc_pkg::MASK_W-1:0] dm_i,
	output logic [ddrc_pkg::DATA_W-1:0] dq_o,
	output int n_cmd_o,
	output int n_pre_o,
	output int n_ref_o,
	output int n_mrs_o,
	output logic [ddrc_pkg::ROW_W-1:0] mrs_val_o
);
	import ddrc_pkg::*;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [ROW_W-1:0] open_row [4];
	logic [DATA_W:0] pipe [16];
	logic [ADDR_W-1:0] wr_addr, cur_addr, a;
	logic [DATA_W-1:0] old;
	logic [2:0] code;
	int hold;
	// Commands count only while chip select is low.
	assign code = cs_n_i ? MC_NOP : {ras_n_i, cas_n_i, we_n_i};
	// Row comes with ACT, column on the same pins, bank apart.
	assign cur_addr = {open_row[bank_i], bank_i, addr_i[COL_W-1:0]};
	initial begin
		{n_cmd_o, n_pre_o, n_ref_o, n_mrs_o, hold} = '0;
		dq_o = '0;
		mrs_val_o = '0;
		foreach (pipe[i]) pipe[i] = '0;
	end
	always @(posedge link_clk_i) begin
		for (int i = 15; i > 0; i--) pipe[i] <= pipe[i-1];
		pipe[0] <= '0;
		if (code != MC_NOP) n_cmd_o <= n_cmd_o + 1;
		case (code)
		MC_PRE: n_pre_o <= n_pre_o + 1;
		MC_REF: n_ref_o <= n_ref_o + 1;
		MC_MRS: begin
			n_mrs_o <= n_mrs_o + 1;
			mrs_val_o <= addr_i;
		end
		MC_ACT: open_row[bank_i] <= addr_i;
		MC_RD: pipe[0] <= {1'b1, mem.exists(cur_addr) ? mem[cur_addr] : 16'h0};
		MC_WR: wr_addr <= cur_addr;
		default: ;
		endcase
		if (dq_oe_i) begin
			a = (code == MC_WR) ? cur_addr : wr_addr;
			old = mem.exists(a) ? mem[a] : 16'h0;
			// A high byte mask keeps the stored byte.
			for (int b = 0; b < MASK_W; b++)
				if (dm_i[b] !== 1'b1) old[8*b +: 8] = dq_i[8*b +: 8];
			mem[a] = old;
		end
		// Read data stands a few cycles, then the bus shows junk.
		if (pipe[CAS_LAT + tap_i - 1][DATA_W]) begin
			dq_o <= pipe[CAS_LAT + tap_i - 1][DATA_W-1:0];
			hold <= 4;
		end else if (hold > 0) hold <= hold - 1;
		else dq_o <= ~dq_o;
	end
endmodule

//--- bench/tb.sv
// Testbench for the controller: user commands against the SDRAM model.
// Assumes the default DDR1 build with repeat and external refresh on.
`timescale 1ns/1ps
module tb;
	import ddrc_pkg::*;
	logic ref_clk_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0;
	logic init_start_i = 1'b0, ext_refresh_i = 1'b0, cmd_valid_i = 1'b0;
	logic [3:0] cmd_i = 4'h0;
	logic [ADDR_W-1:0] addr_i = '0;
	logic [4:0] repeat_count_i = 5'h1;
	logic [DATA_W-1:0] write_data_i = 16'h0;
	logic [MASK_W-1:0] write_mask_i = 2'h0;
	logic [TAP_W-1:0] tap = 3'h1;
	logic sys_clk_o, init_done_o, ack, cmd_rdy_o, wr_data_rdy_o, rd_vld;
	logic dll_n, clk_out, cke, ras_n, cas_n, we_n, cs_n, odt, adv = 1'b0;
	logic burst_term = 1'b0;
	logic [DATA_W-1:0] read_data_o, dq_o, dq_oe, mdl_dq, dq_w;
	logic [ROW_W-1:0] ma, mrs_val;
	logic [BANK_W-1:0] ba;
	logic [MASK_W-1:0] dm, dqs_o, dqs_oe, dqs_w;
	int n_errors = 0, n_compared = 0, n_wr = 0, n_cmd, n_pre, n_ref, n_mrs;
	logic [DATA_W-1:0] rq [$];
	assign dq_w = (dq_oe & dq_o) | (~dq_oe & mdl_dq);
	assign dqs_w = (dqs_oe & dqs_o) | (~dqs_oe & {2{link_clk_i}});
	always #5 ref_clk_i = ~ref_clk_i;
	initial begin
		#2;
		forever begin
			link_clk_i = ~link_clk_i;
			#15;
		end
	end
	ddrc_top dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.link_clk_i(link_clk_i), .system_clock_270_i(1'b0),
		.system_clock_90_i(1'b0), .sys_clk_o(sys_clk_o),
		.init_start_i(init_start_i), .init_done_o(init_done_o),
		.ext_refresh_i(ext_refresh_i), .ext_refresh_ack_o(ack),
		.cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i), .addr_i(addr_i),
		.repeat_count_i(repeat_count_i), .burst_term_i(burst_term),
		.cmd_rdy_o(cmd_rdy_o), .wr_data_rdy_o(wr_data_rdy_o),
		.write_data_i(write_data_i), .write_mask_i(write_mask_i),
		.read_data_o(read_data_o), .read_data_valid_o(rd_vld),
		.read_gate_tap_i(tap), .dll_update_n_o(dll_n),
		.strobe_delay_i(1'b0), .memory_clock_out_o(clk_out),
		.memory_clock_enable_o(cke), .memory_row_col_address_o(ma),
		.memory_bank_select_o(ba), .memory_data_pins_i(dq_w),
		.memory_data_pins_o(dq_o), .memory_data_pins_oe_o(dq_oe),
		.memory_byte_mask_o(dm), .memory_data_strobe_i(dqs_w),
		.memory_data_strobe_o(dqs_o), .memory_data_strobe_oe_o(dqs_oe),
		.memory_chip_select_low_o(cs_n), .memory_row_strobe_low_o(ras_n),
		.memory_column_strobe_low_o(cas_n),
		.memory_write_enable_low_o(we_n),
		.memory_termination_control_o(odt));
	ddrc_mem_model mdl_u (.link_clk_i(link_clk_i), .tap_i(tap),
		.cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
		.addr_i(ma), .bank_i(ba), .dq_i(dq_o), .dq_oe_i(dq_oe[0]),
		.dm_i(dm), .dq_o(mdl_dq), .n_cmd_o(n_cmd), .n_pre_o(n_pre),
		.n_ref_o(n_ref), .n_mrs_o(n_mrs), .mrs_val_o(mrs_val));
	// Each write beat is taken at the edge after its ready cycle.
	always @(negedge ref_clk_i) begin
		if (wr_data_rdy_o === 1'b1) begin
			n_wr++;
			adv = 1'b1;
		end
		if (rd_vld === 1'b1) rq.push_back(read_data_o);
	end
	always @(posedge ref_clk_i) begin
		if (adv) begin
			write_data_i <= write_data_i + 16'h0101;
			adv = 1'b0;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wait_hi(ref logic s);
		int t;
		t = 0;
		do begin
			@(negedge ref_clk_i);
			t++;
		end while (s !== 1'b1 && t < 3000);
	endtask
	task automatic op(input logic [3:0] c, input logic [ADDR_W-1:0] a,
		input logic [4:0] r, input logic [DATA_W-1:0] d,
		input logic [MASK_W-1:0] m);
		@(posedge ref_clk_i);
		cmd_i <= c;
		addr_i <= a;
		repeat_count_i <= r;
		write_data_i <= d;
		write_mask_i <= m;
		cmd_valid_i <= 1'b1;
		wait_hi(cmd_rdy_o);
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		wait_hi(cmd_rdy_o);
		chk("cmd_rdy back", cmd_rdy_o, 1'b1);
		repeat (8) @(negedge ref_clk_i);
	endtask
	task automatic rd_chk(input logic [DATA_W-1:0] exp);
		chk("read beats", rq.size() > 0, 1'b1);
		if (rq.size() > 0) chk("read data", rq.pop_front(), exp);
	endtask
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#400000;
		n_errors++;
		finish_test();
	end
	initial begin
		int r0;
		logic [ADDR_W-1:0] a1, a2;
		a1 = {13'h0005, 2'h1, 10'h008};
		a2 = {13'h0005, 2'h1, 10'h010};
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("rdy in reset", cmd_rdy_o, 1'b0);
		chk("cs in reset", cs_n, 1'b1);
		chk("cke in reset", cke, 1'b0);
		@(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (20000) @(posedge ref_clk_i);
		init_start_i <= 1'b1;
		wait_hi(init_done_o);
		chk("init_done", init_done_o, 1'b1);
		@(posedge ref_clk_i);
		init_start_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("init_done width", init_done_o, 1'b0);
		chk("init pre", n_pre, 1);
		chk("init ref", n_ref, 2);
		chk("init mrs", mrs_val, MODE_REG_DEF);
		chk("cke up", cke, 1'b1);
		chk("sys clk", sys_clk_o, ref_clk_i);
		r0 = n_cmd;
		@(posedge ref_clk_i);
		cmd_i <= UC_READ;
		repeat (20) @(negedge ref_clk_i);
		chk("no valid", n_cmd + rq.size(), r0);
		op(4'h0, a1, 5'h1, 16'h0, 2'h0);
		chk("code 0", n_cmd, r0);
		op(UC_WRITE, a1, 5'h1, 16'h1234, 2'h0);
		op(UC_WRITE, a1, 5'h1, 16'habcd, 2'h1);
		chk("write beats", n_wr, 2);
		op(UC_READ, a1, 5'h1, 16'h0, 2'h0);
		rd_chk(16'hab34);
		op(UC_WRITEA, a2, 5'h2, 16'h1111, 2'h0);
		chk("repeat writes", n_wr, 4);
		op(UC_READA, a2, 5'h2, 16'h0, 2'h0);
		rd_chk(16'h1111);
		rd_chk(16'h1212);
		@(posedge ref_clk_i);
		burst_term <= 1'b1;
		op(UC_READ, a2, 5'h2, 16'h0, 2'h0);
		@(posedge ref_clk_i);
		burst_term <= 1'b0;
		rd_chk(16'h1111);
		chk("burst term", rq.size(), 0);
		chk("odt ddr1", odt, 1'b0);
		chk("dll ddr1", dll_n, 1'b1);
		op(UC_LOAD_MR, {13'h0022, 2'h0, 10'h000}, 5'h1, 16'h0, 2'h0);
		chk("load mr", mrs_val, 13'h0022);
		op(UC_PDOWN, a1, 5'h1, 16'h0, 2'h0);
		chk("pdown cke", cke, 1'b0);
		r0 = n_ref;
		op(UC_SELF_REF, a1, 5'h1, 16'h0, 2'h0);
		chk("self ref", n_ref - r0, 1);
		op(UC_READ, a1, 5'h1, 16'h0, 2'h0);
		chk("cke back", cke, 1'b1);
		rd_chk(16'hab34);
		r0 = n_ref;
		@(posedge ref_clk_i);
		ext_refresh_i <= 1'b1;
		wait_hi(ack);
		chk("ref ack", ack, 1'b1);
		chk("ref burst", n_ref - r0, REF_BURST_DEF);
		@(posedge ref_clk_i);
		ext_refresh_i <= 1'b0;
		@(negedge ref_clk_i);
		chk("ack width", ack, 1'b0);
		chk("no stray reads", rq.size(), 0);
		@(posedge ref_clk_i);
		rstn_i <= 1'b0;
		repeat (8) @(negedge ref_clk_i);
		chk("rdy mid reset", cmd_rdy_o, 1'b0);
		chk("cs mid reset", cs_n, 1'b1);
		@(posedge ref_clk_i);
		rstn_i <= 1'b1;
		repeat (10) @(negedge ref_clk_i);
		chk("waits for init", cmd_rdy_o, 1'b0);
		finish_test();
	end
endmodule
